// ===== hdl/hmc_regs.sv
`timescale 1ns/10ps
`include "hmc_cfg.svh"
// Contract
// - Slave addresses 1 to 247 are accepted and only frames with that address are served.
// - Mode bit 8 picks device-grouped (0) or variable-grouped (1) register layout.
// - A 32-bit float spans two registers, most significant byte first by default.
// - Mode bit 9 swaps the two float words so the low word comes first.
// - HART bits 9:8 pick hold, preset or NaN substitution for a failed device.
// - HART bits 7:6 give 1 to 3 retries, after which the failed value is stored.
// - HART bit 5 selects register fill (0) or transparent modem (1).
// - HART bit 4 selects primary (1) or secondary (0) master role.
// - HART bits 3:0 hold polled device count minus one.
// - Functions 6 and 16 write one register or a contiguous range.
// - Written settings are committed to storage and restored after power-up.
// - Register 772 holds the preset substitution value.
// - Port bits 13:12 encode parity as 00 none, 01 even, 10 odd.
// - Register 776 reports hardware revision high byte, software revision low byte.
module hmc_regs #(
   parameter logic [7:0] HW_REV = 8'h01,
   parameter logic [7:0] SW_REV = 8'h01
) (
   input wire logic ref_clk,
   input wire logic rst,
   // Decoded Modbus frame fields
   input wire logic req_valid,
   input wire logic [7:0] req_slave,
   input wire logic [7:0] req_func,
   input wire logic [15:0] req_addr,
   input wire logic [15:0] req_data,
   input wire logic req_last,
   // Poll sequencer status
   input wire logic [15:0] dev_health,
   input wire logic poll_fail,
   input wire logic [31:0] last_float,
   input wire logic [15:0] last_int,
   // Responses
   output logic rsp_valid,
   output logic rsp_err,
   output logic [15:0] rsp_data,
   // Configuration outputs, substitution values and restore status
   output logic [15:0] preset_value,
   output logic [1:0] fail_mode,
   output logic [1:0] retry_count,
   output logic modem_mode,
   output logic primary_master,
   output logic [3:0] poll_count_m1,
   output logic map_by_var,
   output logic float_swap,
   output logic [1:0] parity,
   output logic [3:0] baud_code,
   output logic [7:0] slave_addr,
   output logic [31:0] subst_float,
   output logic [15:0] subst_int,
   output logic [15:0] float_hi_word,
   output logic [15:0] float_lo_word,
   output logic restore_done
);
   ////////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] FN_READ = 8'h03;
   localparam logic [7:0] FN_WR1 = 8'h06;
   localparam logic [7:0] FN_WRN = 8'h10;
   localparam logic [31:0] NAN_F = 32'h7fc00000;

   typedef enum logic [1:0] {
      ST_RESTORE,
      ST_WAIT,
      ST_RUN
   } hmc_state_e;

   hmc_state_e state_q;
   logic [1:0] rst_idx_q;
   logic [15:0] preset_q, hart_q, mode_q, port_q;
   logic nvm_we;
   logic [1:0] nvm_wa;
   logic [15:0] nvm_wd;
   logic [15:0] nvm_rd;
   logic [1:0] nvm_ra;
   logic addr_hit;
   logic wr_ok;
   logic [15:0] wr_val;
   logic [2:0] wr_idx;
   hmc_pkg::hmc_fail_e fail_code;

   // Index of a writable register, 4 for none
   function automatic logic [2:0] cfg_index(input logic [15:0] a);
      unique case (a)
         `HMC_ADDR_PRESET: cfg_index = 3'd0;
         `HMC_ADDR_HART: cfg_index = 3'd1;
         `HMC_ADDR_MODE: cfg_index = 3'd2;
         `HMC_ADDR_PORT: cfg_index = 3'd3;
         default: cfg_index = 3'd4;
      endcase
   endfunction

   // Port word with an out-of-range address is refused
   function automatic logic port_legal(input logic [15:0] v);
      port_legal = (v[7:0] >= `HMC_ADDR_MIN) && (v[7:0] <= `HMC_ADDR_MAX) &&
                   (v[13:12] != 2'b11);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // own address only
   assign addr_hit = req_valid && (req_slave == slave_addr) && (state_q == ST_RUN);
   // Decoded once, shared by the write check, the mask and the storage port
   assign wr_idx = cfg_index(req_addr);
   assign wr_ok = addr_hit && ((req_func == FN_WR1) || (req_func == FN_WRN)) &&
                  (wr_idx != 3'd4) &&
                  ((wr_idx != 3'd3) || port_legal(req_data));
   always_comb begin
      wr_val = req_data;
      unique case (wr_idx)
         3'd1: wr_val = req_data & `HMC_MASK_HART;
         3'd2: wr_val = req_data & `HMC_MASK_MODE;
         3'd3: wr_val = req_data & `HMC_MASK_PORT;
         default: wr_val = req_data;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // write-through storage
   assign nvm_we = wr_ok;
   assign nvm_wa = wr_idx[1:0];
   assign nvm_wd = wr_val;
   assign nvm_ra = rst_idx_q;

   hmc_nvm #(.WORDS(4), .AW(2)) u_nvm (
      .ref_clk(ref_clk),
      .wr_en(nvm_we),
      .wr_addr(nvm_wa),
      .wr_data(nvm_wd),
      .rd_addr(nvm_ra),
      .rd_data(nvm_rd)
   );

   // Restore walk: one word per two cycles, keeps the read port simple
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_RESTORE;
      end else begin
         unique case (state_q)
            ST_RESTORE: state_q <= ST_WAIT;
            ST_WAIT: begin
               if (rst_idx_q == 2'd3) begin
                  state_q <= ST_RUN;
               end else begin
                  state_q <= ST_RESTORE;
               end
            end
            ST_RUN: state_q <= ST_RUN;
            // The fourth code is unused; fall back to ST_RESTORE, keeping the current word index
            default: state_q <= ST_RESTORE;
         endcase
      end
   end

   // Storage word index, stepped after each word is taken
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rst_idx_q <= 2'd0;
      end else if ((state_q == ST_WAIT) && (rst_idx_q != 2'd3)) begin
         rst_idx_q <= rst_idx_q + 2'd1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Storage may hold garbage on first power-up; only legal port words are loaded
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         preset_q <= `HMC_RST_PRESET;
         hart_q <= `HMC_RST_HART;
         mode_q <= `HMC_RST_MODE;
         port_q <= `HMC_RST_PORT;
      end else if (state_q == ST_WAIT) begin
         unique case (rst_idx_q)
            2'd0: preset_q <= nvm_rd;
            2'd1: hart_q <= nvm_rd & `HMC_MASK_HART;
            2'd2: mode_q <= nvm_rd & `HMC_MASK_MODE;
            2'd3: begin
               if (port_legal(nvm_rd)) begin
                  port_q <= nvm_rd & `HMC_MASK_PORT;
               end
            end
         endcase
      end else if (wr_ok) begin
         unique case (wr_idx)
            3'd0: preset_q <= wr_val;
            3'd1: hart_q <= wr_val;
            3'd2: mode_q <= wr_val;
            default: port_q <= wr_val;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         restore_done <= 1'b0;
      end else begin
         restore_done <= (state_q == ST_RUN);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Field outputs, all registered, one block for each register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         preset_value <= `HMC_RST_PRESET;
      end else begin
         preset_value <= preset_q;
      end
   end

   // Reset values follow the factory word of the HART settings register
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         fail_mode <= 2'b00;
         retry_count <= 2'b01;
         modem_mode <= 1'b0;
         primary_master <= 1'b1;
         poll_count_m1 <= 4'h0;
      end else begin
         fail_mode <= hart_q[`HMC_HART_FAIL_LSB +: 2];
         retry_count <= (hart_q[`HMC_HART_RETRY_LSB +: 2] == 2'b00) ? 2'b01 :
                        hart_q[`HMC_HART_RETRY_LSB +: 2];
         modem_mode <= hart_q[`HMC_HART_MODEM_BIT];
         primary_master <= hart_q[`HMC_HART_PRIMARY_BIT];
         poll_count_m1 <= hart_q[3:0];
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         map_by_var <= 1'b0;
         float_swap <= 1'b0;
      end else begin
         map_by_var <= mode_q[`HMC_MODE_MAP_BIT];
         float_swap <= mode_q[`HMC_MODE_SWAP_BIT];
      end
   end

   // Factory port word is address 1 with odd parity
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         parity <= 2'b10;
         baud_code <= 4'h0;
         slave_addr <= `HMC_ADDR_MIN;
      end else begin
         parity <= port_q[`HMC_PORT_PAR_LSB +: 2];
         baud_code <= port_q[`HMC_PORT_BAUD_LSB +: 4];
         slave_addr <= port_q[7:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Failed action code, shared by both substitution registers
   assign fail_code = hmc_pkg::hmc_fail_e'(hart_q[`HMC_HART_FAIL_LSB +: 2]);

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         subst_float <= 32'h00000000;
      end else if (poll_fail) begin
         unique case (fail_code)
            // preset widened to the float pair
            hmc_pkg::HMC_FAIL_PRESET: begin
               subst_float <= {16'h0000, preset_q};
            end
            hmc_pkg::HMC_FAIL_NAN: begin
               subst_float <= NAN_F;
            end
            default: begin
               subst_float <= last_float;
            end
         endcase
      end
   end

   // Integer registers take zero where floats take NaN
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         subst_int <= 16'h0000;
      end else if (poll_fail) begin
         unique case (fail_code)
            hmc_pkg::HMC_FAIL_PRESET: begin
               subst_int <= preset_q;
            end
            hmc_pkg::HMC_FAIL_NAN: begin
               subst_int <= 16'h0000;
            end
            default: begin
               subst_int <= last_int;
            end
         endcase
      end
   end

   hmc_float_order u_order (
      .ref_clk(ref_clk),
      .rst(rst),
      .swap(float_swap),
      .value(subst_float),
      .word_first(float_hi_word),
      .word_second(float_lo_word)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Middle beats of a range write stay silent, so a frame gets one answer
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rsp_valid <= 1'b0;
      end else begin
         rsp_valid <= addr_hit && (req_last || (req_func == FN_READ));
      end
   end

   // Answer every frame for this address; unmapped reads are an error
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rsp_err <= 1'b0;
         rsp_data <= 16'h0000;
      end else begin
         rsp_err <= 1'b0;
         rsp_data <= 16'h0000;
         if (addr_hit && (req_func == FN_READ)) begin
            unique case (req_addr)
               `HMC_ADDR_PRESET: rsp_data <= preset_q;
               `HMC_ADDR_HART: rsp_data <= hart_q;
               `HMC_ADDR_MODE: rsp_data <= mode_q;
               `HMC_ADDR_PORT: rsp_data <= port_q;
               `HMC_ADDR_REV: rsp_data <= {HW_REV, SW_REV};
               `HMC_ADDR_HEALTH: rsp_data <= dev_health;
               default: rsp_err <= 1'b1;
            endcase
         end else if (addr_hit && !wr_ok) begin
            rsp_err <= 1'b1;
         end else if (addr_hit) begin
            rsp_data <= wr_val;
         end
      end
   end
endmodule

// ===== hdl/hmc_cfg.svh
`ifndef HMC_CFG_SVH
`define HMC_CFG_SVH
// Register addresses
`define HMC_ADDR_PRESET 16'h0304
`define HMC_ADDR_HART 16'h0305
`define HMC_ADDR_MODE 16'h0306
`define HMC_ADDR_PORT 16'h0307
`define HMC_ADDR_REV 16'h0308
`define HMC_ADDR_HEALTH 16'h0309
// Field positions
`define HMC_HART_FAIL_LSB 8
`define HMC_HART_RETRY_LSB 6
`define HMC_HART_MODEM_BIT 5
`define HMC_HART_PRIMARY_BIT 4
`define HMC_MODE_MAP_BIT 8
`define HMC_MODE_SWAP_BIT 9
`define HMC_PORT_PAR_LSB 12
`define HMC_PORT_BAUD_LSB 8
// Reset and factory values
`define HMC_RST_PRESET 16'h07cf
`define HMC_RST_HART 16'h0050
`define HMC_RST_MODE 16'h0000
`define HMC_RST_PORT 16'h2001
`define HMC_ADDR_MIN 8'h01
`define HMC_ADDR_MAX 8'hf7
// Writable bit masks
`define HMC_MASK_HART 16'h03ff
`define HMC_MASK_MODE 16'h0300
`define HMC_MASK_PORT 16'h3fff
`endif

// ===== hdl/hmc_pkg.sv
package hmc_pkg;
   typedef enum logic [1:0] {
      HMC_FAIL_HOLD,
      HMC_FAIL_PRESET,
      HMC_FAIL_NAN,
      HMC_FAIL_RSVD
   } hmc_fail_e;
   typedef enum logic [1:0] {
      HMC_PAR_NONE,
      HMC_PAR_EVEN,
      HMC_PAR_ODD,
      HMC_PAR_RSVD
   } hmc_parity_e;
   typedef logic [15:0] hmc_word_t;
endpackage

// ===== hdl/hmc_nvm.sv
`timescale 1ns/10ps
// Small word store standing in for nonvolatile storage; read data registered
module hmc_nvm #(
   parameter int WORDS = 4,
   parameter int AW = 2
) (
   input wire logic ref_clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [15:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [15:0] rd_data
);
   logic [15:0] mem [WORDS];
   always_ff @(posedge ref_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
   end
endmodule

// ===== hdl/hmc_float_order.sv
`timescale 1ns/10ps
`include "hmc_cfg.svh"
// Splits a float into two registers, high word first unless swapped
module hmc_float_order (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic swap,
   input wire logic [31:0] value,
   output logic [15:0] word_first,
   output logic [15:0] word_second
);
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         word_first <= 16'h0000;
         word_second <= 16'h0000;
      end else begin
         word_first <= swap ? value[15:0] : value[31:16];
         word_second <= swap ? value[31:16] : value[15:0];
      end
   end
endmodule

// ===== sim/hmc_regs_properties.sv
`timescale 1ns/10ps
module hmc_regs_properties #(
   parameter logic [7:0] HW_REV = 8'h01,
   parameter logic [7:0] SW_REV = 8'h01
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic [7:0] req_slave,
   input wire logic [7:0] req_func,
   input wire logic [15:0] req_addr,
   input wire logic [15:0] req_data,
   input wire logic req_last,
   input wire logic poll_fail,
   input wire logic rsp_valid,
   input wire logic rsp_err,
   input wire logic [15:0] rsp_data,
   input wire logic [15:0] preset_value,
   input wire logic [1:0] fail_mode,
   input wire logic modem_mode,
   input wire logic primary_master,
   input wire logic [3:0] poll_count_m1,
   input wire logic map_by_var,
   input wire logic float_swap,
   input wire logic [7:0] slave_addr,
   input wire logic [31:0] subst_float,
   input wire logic [15:0] float_hi_word,
   input wire logic [15:0] float_lo_word,
   input wire logic restore_done
);
   // Only accesses after restore count, earlier ones are dropped by design
   wire tk = restore_done && req_valid && req_slave == slave_addr;
   wire wr = tk && (req_func == 8'h06 || req_func == 8'h10);
   wire [15:0] d = req_data;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_foreign_silent: assert property (req_valid && req_slave != slave_addr |=> !rsp_valid)
      else $error("answer to foreign slave");
   a_rev_read: assert property (tk && req_func == 8'h03 && req_addr == 16'h0308
      |=> rsp_valid && !rsp_err && rsp_data == {HW_REV, SW_REV}) else $error("bad revision");
   a_hart_fields: assert property (wr && req_addr == 16'h0305 |=> ##1
      {fail_mode, modem_mode, primary_master, poll_count_m1} == $past({d[9:8], d[5:0]}, 2))
      else $error("hart fields wrong");
   a_mode_fields: assert property (wr && req_addr == 16'h0306 |=> ##1
      {float_swap, map_by_var} == $past(d[9:8], 2)) else $error("mode fields wrong");
   a_port_refuse: assert property (wr && req_last && req_addr == 16'h0307
      && (d[7:0] == 8'h00 || d[7:0] > 8'hf7 || d[13:12] == 2'h3)
      |=> rsp_valid && rsp_err ##1 $stable(slave_addr)) else $error("bad port write taken");
   a_float_order: assert property (restore_done && $stable(subst_float) && $stable(float_swap)
      |-> {float_hi_word, float_lo_word} == (float_swap ? {subst_float[15:0],
      subst_float[31:16]} : subst_float)) else $error("float word order wrong");
   a_preset_subst: assert property (poll_fail && fail_mode == 2'h1
      |=> subst_float == {16'h0000, $past(preset_value)}) else $error("preset not loaded");
   a_nan_subst: assert property (poll_fail && fail_mode == 2'h2
      |=> subst_float == 32'h7fc00000) else $error("nan not loaded");
   c_range_write: cover property (wr && req_func == 8'h10);
   c_nan_fail: cover property (poll_fail && fail_mode == 2'h2);
   c_refused: cover property (rsp_valid && rsp_err);
endmodule
////////////////////////////////////////
bind hmc_regs hmc_regs_properties #(.HW_REV(HW_REV), .SW_REV(SW_REV)) u_props (.*);

// ===== sim/hmc_master_model.sv
`timescale 1ns/10ps
module hmc_master_model (
   input wire logic ref_clk,
   output logic req_valid,
   output logic [7:0] req_slave,
   output logic [7:0] req_func,
   output logic [15:0] req_addr,
   output logic [15:0] req_data,
   output logic req_last
);
   initial begin
      req_valid = 1'b0;
      {req_slave, req_func, req_addr, req_data, req_last} = '0;
   end
   task automatic send(input logic [7:0] sl, fn, input logic [15:0] a, dt, input logic last);
      @(negedge ref_clk);
      req_valid = 1'b1;
      {req_slave, req_func, req_addr, req_data, req_last} = {sl, fn, a, dt, last};
   endtask
   // Released slave, function, address and data lines are inverted so a stale value never looks held
   task automatic idle();
      @(negedge ref_clk);
      req_valid = 1'b0;
      {req_slave, req_func, req_addr, req_data} = ~{req_slave, req_func, req_addr, req_data};
   endtask
endmodule

// ===== sim/hmc_regs_tb.sv
`timescale 1ns/10ps
module hmc_regs_tb;
   logic ref_clk, rst, req_valid, req_last, poll_fail, rsp_valid, rsp_err, restore_done;
   logic modem_mode, primary_master, map_by_var, float_swap;
   logic [1:0] fail_mode, retry_count, parity, r;
   logic [3:0] poll_count_m1, baud_code;
   logic [7:0] req_slave, req_func, slave_addr, sl;
   logic [15:0] req_addr, req_data, dev_health, last_int, rsp_data, preset_value;
   logic [15:0] subst_int, float_hi_word, float_lo_word, v, hv[3], bad[3];
   logic [31:0] last_float, subst_float;
   logic [47:0] ex[3];
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;
   hmc_regs u_dut (.*);
   hmc_master_model u_mst (.*);
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   // Whole run needs under a hundred cycles
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_mismatch++;
         stop_test();
      end
   end
   ////////////////////////////////////////
   task automatic stop_test();
      $display("mismatches %0d compares %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [47:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ticks(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // e holds answer valid, error and data
   task automatic acc(input logic [7:0] fn, input logic [15:0] a, d, input logic [17:0] e);
      u_mst.send(sl, fn, a, d, 1'b1);
      u_mst.idle();
      chk({rsp_valid, rsp_err}, e[17:16]);
      if (e[17:16] == 2'b10) begin
         chk(rsp_data, e[15:0]);
      end
   endtask
   task automatic restart();
      rst = 1'b1;
      ticks(4);
      rst = 1'b0;
      for (int i = 0; i < 50 && restore_done !== 1'b1; i++) @(negedge ref_clk);
      chk(restore_done, 1'b1);
   endtask
   ////////////////////////////////////////
   initial begin
      poll_fail = 1'b0;
      dev_health = 16'h00a5;
      last_float = 32'h41424344;
      last_int = 16'h5566;
      sl = 8'h01;
      hv = '{16'h0000, 16'h01df, 16'h02b7};
      bad = '{16'h2000, 16'h20f8, 16'h3005};
      ex = '{48'h41424344_5566, 48'h00001234_1234, 48'h7fc00000_0000};
      restart();
      chk({parity, baud_code, slave_addr}, {2'h2, 4'h0, 8'h01});
      acc(8'h03, 16'h0308, 16'h0000, {2'b10, 16'h0101});
      acc(8'h03, 16'h0309, 16'h0000, {2'b10, 16'h00a5});
      acc(8'h03, 16'h0303, 16'h0000, {2'b11, 16'h0000});
      u_mst.send(sl, 8'h10, 16'h0304, 16'h1234, 1'b0);
      u_mst.send(sl, 8'h10, 16'h0305, 16'h0000, 1'b0);
      acc(8'h10, 16'h0306, 16'h0300, {2'b10, 16'h0300});
      ticks(1);
      chk({map_by_var, float_swap, preset_value}, {2'b11, 16'h1234});
      for (int i = 0; i < 3; i++) begin
         v = hv[i];
         r = (v[7:6] == 2'h0) ? 2'h1 : v[7:6];
         acc(8'h06, 16'h0305, v, {2'b10, v});
         ticks(1);
         chk({fail_mode, retry_count}, {v[9:8], r});
         chk({modem_mode, primary_master, poll_count_m1}, v[5:0]);
         poll_fail = 1'b1;
         ticks(1);
         poll_fail = 1'b0;
         ticks(2);
         chk({subst_float, subst_int}, ex[i]);
         chk({float_lo_word, float_hi_word}, ex[i][47:16]);
      end
      acc(8'h06, 16'h0306, 16'h0000, {2'b10, 16'h0000});
      ticks(2);
      chk({map_by_var, float_hi_word, float_lo_word}, {1'b0, 32'h7fc00000});
      acc(8'h06, 16'h0307, 16'h1a05, {2'b10, 16'h1a05});
      ticks(1);
      chk({parity, baud_code, slave_addr}, {2'h1, 4'ha, 8'h05});
      acc(8'h03, 16'h0308, 16'h0000, 18'h0);
      sl = 8'h05;
      foreach (bad[k]) acc(8'h06, 16'h0307, bad[k], {2'b11, 16'h0000});
      acc(8'h06, 16'h0308, 16'h0000, {2'b11, 16'h0000});
      acc(8'h06, 16'h0307, 16'h20f7, {2'b10, 16'h20f7});
      sl = 8'hf7;
      ticks(1);
      chk({parity, baud_code, slave_addr}, {2'h2, 4'h0, 8'hf7});
      restart();
      chk({parity, slave_addr, preset_value}, {2'h2, 8'hf7, 16'h1234});
      chk({float_swap, fail_mode, poll_count_m1}, {1'b0, 2'h2, 4'h7});
      acc(8'h03, 16'h0307, 16'h0000, {2'b10, 16'h20f7});
      stop_test();
   end
endmodule
